/* src/oscctl_regs.svh */
`ifndef OSCCTL_REGS_SVH
`define OSCCTL_REGS_SVH

`define OSCCTL_ADDR_W          12
`define OSCCTL_OFF_SOURCE      12'h88e
`define OSCCTL_OFF_READY       12'h890
`define OSCCTL_OFF_FORCE       12'h891
`define OSCCTL_OFF_TRIM        12'h892
`define OSCCTL_OFF_RATE        12'h893

`define OSCCTL_SRC_LSB         4
`define OSCCTL_SRC_MSB         5
`define OSCCTL_BIT_FAST        6
`define OSCCTL_BIT_MEDIUM      5
`define OSCCTL_BIT_SLOW        4
`define OSCCTL_BIT_CONV        2
`define OSCCTL_BIT_SPECIAL     1
`define OSCCTL_FORCE_MASK      8'h74
`define OSCCTL_TRIM_MASK       8'h3f
`define OSCCTL_RATE_MASK       8'h07

`define OSCCTL_TRIM_RST        6'h00
`define OSCCTL_FORCE_RST       8'h00
`define OSCCTL_RATE_1MHZ       3'h0
`define OSCCTL_RATE_16MHZ      3'h4
`define OSCCTL_RATE_32MHZ      3'h5
`define OSCCTL_RATE_MAX        3'h5

`define OSCCTL_CLK_MHZ         250
`define OSCCTL_START_NS        1000
`define OSCCTL_START_CYC       ((`OSCCTL_START_NS * `OSCCTL_CLK_MHZ + 999) / 1000)
`define OSCCTL_SLEW_NS         16
`define OSCCTL_SLEW_CYC        ((`OSCCTL_SLEW_NS * `OSCCTL_CLK_MHZ + 999) / 1000)
`define OSCCTL_MED_500K_NS     2000
`define OSCCTL_MED_31K_NS      32000
`define OSCCTL_MED_500K_HALF   ((`OSCCTL_MED_500K_NS * `OSCCTL_CLK_MHZ) / 2000)
`define OSCCTL_MED_31K_HALF    ((`OSCCTL_MED_31K_NS * `OSCCTL_CLK_MHZ) / 2000)

`endif

/* src/oscctl_pkg.sv */
package oscctl_pkg;
  typedef enum logic [1:0] {
    OSCCTL_SRC_HF32,
    OSCCTL_SRC_SLOW,
    OSCCTL_SRC_HF1,
    OSCCTL_SRC_EXT
  } oscctl_src_e;
  typedef logic [2:0] oscctl_rate_t;
  typedef logic [5:0] oscctl_trim_t;
endpackage

/* src/oscctl_osc_ready.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oscctl_regs.svh"
// Models one oscillator's start-up: ready rises a fixed time after run, drops at once.
module oscctl_osc_ready (
  input  wire logic sys_clk,   // System clock
  input  wire logic rst_b,     // Async reset, active low
  input  wire logic clk_en,    // Clock enable
  input  wire logic run,       // Oscillator requested to run
  output logic      ready      // Oscillator stable
);
  logic [9:0] cnt_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 10'h000;
      ready <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_q <= 10'h000;
        ready <= 1'b0;
      end else if (cnt_q == 10'(`OSCCTL_START_CYC - 1)) begin
        ready <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end

  AST_READY_DROPS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !run |=> !ready)
    else $error("ready held while oscillator stopped");
endmodule
`default_nettype wire

/* src/oscctl_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oscctl_regs.svh"
module oscctl_top (
  input  wire logic        sys_clk,              // 250 MHz system clock
  input  wire logic        rst_b,                // Async reset, active low
  input  wire logic        clk_en,               // Freezes all state while low
  input  wire logic [1:0]  reset_source_setting, // Configuration strap, caught at reset release
  input  wire logic [11:0] addr,                 // Register byte address
  input  wire logic [7:0]  wdata,                // Write data
  input  wire logic        wr,                   // Write strobe
  input  wire logic        rd,                   // Read strobe
  input  wire logic        fast_req,             // Peripheral request for fast oscillator
  input  wire logic        medium_req,           // Peripheral request for medium oscillator
  input  wire logic        slow_req,             // Peripheral request for slow oscillator
  input  wire logic        conv_req,             // Peripheral request for converter RC
  input  wire logic        special_req,          // Peripheral request for special oscillator
  output logic [7:0]       rdata,                // Read data, valid the cycle after rd
  output logic [1:0]       active_source,        // Current clock source code
  output logic             fast_run,             // Fast oscillator enable
  output logic             medium_run,           // Medium oscillator enable
  output logic             slow_run,             // Slow oscillator enable
  output logic             conv_run,             // Converter RC enable
  output logic             special_run,          // Special oscillator enable
  output logic [2:0]       fast_rate_out,        // Applied fast rate code
  output logic [5:0]       fast_trim_out,        // Applied trim, slewed
  output logic             med_tick_500k,        // One-cycle 500 kHz tick
  output logic             med_tick_31k          // One-cycle 31.25 kHz tick
);
  logic [7:0]                 force_q;
  oscctl_pkg::oscctl_trim_t   fast_trim_code_q;
  oscctl_pkg::oscctl_rate_t   fast_rate_code_q;
  oscctl_pkg::oscctl_src_e    src_q;
  logic                       strap_done_q;
  logic                       fast_ok;
  logic                       medium_ok;
  logic                       slow_ok;
  logic                       conv_ok;
  logic                       special_ok;
  logic [7:0]                 ready_flags;
  logic [3:0]                 slew_q;
  logic [8:0]                 div500_q;
  logic [12:0]                div31_q;

  function automatic logic fwr(input logic [11:0] a);
    fwr = wr && (addr == a);
  endfunction

  // Strap is sampled by a clock edge after release; an async load would race the pin.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_q        <= oscctl_pkg::OSCCTL_SRC_HF32;
      strap_done_q <= 1'b0;
    end else if (clk_en && !strap_done_q) begin
      src_q        <= oscctl_pkg::oscctl_src_e'(reset_source_setting);
      strap_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      force_q <= `OSCCTL_FORCE_RST;
    end else if (clk_en && fwr(`OSCCTL_OFF_FORCE)) begin
      force_q <= wdata & `OSCCTL_FORCE_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_trim_code_q <= `OSCCTL_TRIM_RST;
    end else if (clk_en && fwr(`OSCCTL_OFF_TRIM)) begin
      fast_trim_code_q <= wdata[5:0];
    end
  end

  // Rate follows the strap once; reserved codes are kept out so the divider never sees them.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_rate_code_q <= `OSCCTL_RATE_16MHZ;
    end else if (clk_en) begin
      if (!strap_done_q) begin
        if (reset_source_setting == 2'h2) begin
          fast_rate_code_q <= `OSCCTL_RATE_1MHZ;
        end else if (reset_source_setting == 2'h0) begin
          fast_rate_code_q <= `OSCCTL_RATE_32MHZ;
        end
      end else if (fwr(`OSCCTL_OFF_RATE) && wdata[2:0] <= `OSCCTL_RATE_MAX) begin
        fast_rate_code_q <= wdata[2:0];
      end
    end
  end

  // Enable = force bit OR request (special: request only); fast also runs as system clock or for medium/special, slow as system clock.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_run    <= 1'b0;
      medium_run  <= 1'b0;
      slow_run    <= 1'b0;
      conv_run    <= 1'b0;
      special_run <= 1'b0;
    end else if (clk_en) begin
      medium_run  <= force_q[`OSCCTL_BIT_MEDIUM] | medium_req;
      slow_run    <= force_q[`OSCCTL_BIT_SLOW] | slow_req
                     | (src_q == oscctl_pkg::OSCCTL_SRC_SLOW);
      conv_run    <= force_q[`OSCCTL_BIT_CONV] | conv_req;
      special_run <= special_req;
      fast_run    <= force_q[`OSCCTL_BIT_FAST] | fast_req
                     | medium_run | special_run
                     | (src_q == oscctl_pkg::OSCCTL_SRC_HF32)
                     | (src_q == oscctl_pkg::OSCCTL_SRC_HF1);
    end
  end

  oscctl_osc_ready u_fast (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .run     (fast_run),
    .ready   (fast_ok)
  );
  oscctl_osc_ready u_medium (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .run     (medium_run & fast_ok),
    .ready   (medium_ok)
  );
  oscctl_osc_ready u_slow (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .run     (slow_run),
    .ready   (slow_ok)
  );
  oscctl_osc_ready u_conv (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .run     (conv_run),
    .ready   (conv_ok)
  );
  oscctl_osc_ready u_special (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .run     (special_run & fast_ok),
    .ready   (special_ok)
  );

  always_comb begin
    ready_flags                      = 8'h00;
    ready_flags[`OSCCTL_BIT_FAST]    = fast_ok;
    ready_flags[`OSCCTL_BIT_MEDIUM]  = medium_ok;
    ready_flags[`OSCCTL_BIT_SLOW]    = slow_ok;
    ready_flags[`OSCCTL_BIT_CONV]    = conv_ok;
    ready_flags[`OSCCTL_BIT_SPECIAL] = special_ok;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      if (rd) begin
        case (addr)
          `OSCCTL_OFF_SOURCE: rdata <= {2'h0, src_q, 4'h0};
          `OSCCTL_OFF_READY:  rdata <= ready_flags;
          `OSCCTL_OFF_FORCE:  rdata <= force_q;
          `OSCCTL_OFF_TRIM:   rdata <= {2'h0, fast_trim_code_q};
          `OSCCTL_OFF_RATE:   rdata <= {5'h00, fast_rate_code_q};
          default:            rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_source <= 2'h0;
      fast_rate_out <= `OSCCTL_RATE_16MHZ;
    end else if (clk_en) begin
      active_source <= src_q;
      fast_rate_out <= fast_rate_code_q;
    end
  end

  // Trim moves one signed step per slew period; no done flag, by design.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slew_q        <= 4'h0;
      fast_trim_out <= `OSCCTL_TRIM_RST;
    end else if (clk_en) begin
      if (slew_q == 4'(`OSCCTL_SLEW_CYC - 1)) begin
        slew_q <= 4'h0;
        if ($signed(fast_trim_out) < $signed(fast_trim_code_q)) begin
          fast_trim_out <= fast_trim_out + 6'h01;
        end else if ($signed(fast_trim_out) > $signed(fast_trim_code_q)) begin
          fast_trim_out <= fast_trim_out - 6'h01;
        end
      end else begin
        slew_q <= slew_q + 4'h1;
      end
    end
  end

  // Fixed periods counted on the reference clock, so the ticks ignore the rate code.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div500_q      <= 9'h000;
      div31_q       <= 13'h0000;
      med_tick_500k <= 1'b0;
      med_tick_31k  <= 1'b0;
    end else if (clk_en) begin
      med_tick_500k <= 1'b0;
      med_tick_31k  <= 1'b0;
      if (!medium_ok) begin
        div500_q <= 9'h000;
        div31_q  <= 13'h0000;
      end else begin
        // A 500-cycle period needs nine bits; eight would wrap early
        if (div500_q == 9'(2 * `OSCCTL_MED_500K_HALF - 1)) begin
          div500_q      <= 9'h000;
          med_tick_500k <= 1'b1;
        end else begin
          div500_q <= div500_q + 9'h001;
        end
        if (div31_q == 13'(2 * `OSCCTL_MED_31K_HALF - 1)) begin
          div31_q      <= 13'h0000;
          med_tick_31k <= 1'b1;
        end else begin
          div31_q <= div31_q + 13'h0001;
        end
      end
    end
  end

  sequence s_force_fast;
    clk_en && force_q[`OSCCTL_BIT_FAST];
  endsequence

  AST_FAST_FORCED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_force_fast |=> fast_run)
    else $error("fast oscillator not running while forced");
  AST_MEDIUM_FORCED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && force_q[`OSCCTL_BIT_MEDIUM] |=> medium_run)
    else $error("medium oscillator not running while forced");
  AST_SLOW_FORCED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && force_q[`OSCCTL_BIT_SLOW] |=> slow_run)
    else $error("slow oscillator not running while forced");
  AST_CONV_FORCED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && force_q[`OSCCTL_BIT_CONV] |=> conv_run)
    else $error("converter RC not running while forced");
  AST_CONV_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !force_q[`OSCCTL_BIT_CONV] && !conv_req |=> !conv_run)
    else $error("converter RC running with no cause");
  AST_READY_REPORT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && rd && addr == `OSCCTL_OFF_READY |=> rdata == $past(ready_flags))
    else $error("ready register read mismatch");
  AST_SOURCE_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && rd && addr == `OSCCTL_OFF_SOURCE |=> rdata[5:4] == $past(src_q)
                                                   && rdata[7:6] == 2'h0)
    else $error("source field read mismatch");
  AST_RATE_NO_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fast_rate_code_q <= `OSCCTL_RATE_MAX)
    else $error("reserved rate code stored");
  AST_FORCE_UNUSED_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (force_q & ~`OSCCTL_FORCE_MASK) == 8'h00)
    else $error("unimplemented force bit set");
  AST_TRIM_STEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $changed(fast_trim_out) |->
      (fast_trim_out - $past(fast_trim_out) == 6'h01
       || $past(fast_trim_out) - fast_trim_out == 6'h01))
    else $error("trim jumped more than one step");
  AST_MED_TICK_GAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    med_tick_500k |=> !med_tick_500k)
    else $error("500 kHz tick wider than one cycle");
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk;
  logic        rst_b;
  logic        clk_en;
  logic [1:0]  reset_source_setting;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [4:0]  req;
  logic [7:0]  rdata;
  logic [1:0]  active_source;
  logic        fast_run;
  logic        medium_run;
  logic        slow_run;
  logic        conv_run;
  logic        special_run;
  logic [2:0]  fast_rate_out;
  logic [5:0]  fast_trim_out;
  logic        med_tick_500k;
  logic        med_tick_31k;
  integer      seed;
  int          n_errors;
  int          checks_done;
  int          cyc;
  int          n5;
  int          n31;
  logic [7:0]  prev;
  logic [7:0]  v;

  oscctl_top oscctl_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reset_source_setting(reset_source_setting), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .fast_req(req[4]), .medium_req(req[3]), .slow_req(req[2]),
    .conv_req(req[1]), .special_req(req[0]), .rdata(rdata),
    .active_source(active_source), .fast_run(fast_run), .medium_run(medium_run),
    .slow_run(slow_run), .conv_run(conv_run), .special_run(special_run),
    .fast_rate_out(fast_rate_out), .fast_trim_out(fast_trim_out),
    .med_tick_500k(med_tick_500k), .med_tick_31k(med_tick_31k)
  );

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Generous ceiling: the full sequence needs roughly 19k cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic do_reset(input logic [1:0] s);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    reset_source_setting <= s;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_cyc(3);
  endtask

  // Medium and special oscillators need the fast one running underneath
  function automatic logic [7:0] exp_rdy(input logic [7:0] frc, input logic [4:0] r);
    logic f;
    logic m;
    m = frc[5] | r[3];
    f = frc[6] | r[4] | m | r[0];
    return {1'b0, f, m, frc[4] | r[2], 1'b0, frc[2] | r[1], r[0], 1'b0};
  endfunction

  initial begin
    seed = 40109;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    reset_source_setting = 2'h3;
    addr = 12'h000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    req = 5'h00;
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      chk({6'h00, active_source}, {6'h00, s[1:0]});
      reg_rd(12'h88e, {2'h0, s[1:0], 4'h0});
      v = (s == 2) ? 8'h00 : (s == 0) ? 8'h05 : 8'h04;
      reg_rd(12'h893, v);
      reg_rd(12'h890, 8'h00);
      reg_rd(12'h891, 8'h00);
      reg_rd(12'h892, 8'h00);
    end
    // External source from here on, so nothing runs unless asked
    reg_wr(12'h88e, 8'h00);
    reg_wr(12'h890, 8'hff);
    reg_rd(12'h88f, 8'h00);
    reg_rd(12'h88e, 8'h30);
    wait_cyc(1);
    chk(rdata, 8'h00);
    reg_wr(12'h891, 8'hff);
    reg_rd(12'h891, 8'h74);
    wait_cyc(600);
    reg_rd(12'h890, 8'h74);
    chk({3'h0, fast_run, medium_run, slow_run, conv_run, special_run}, 8'h1e);
    n5 = 0;
    n31 = 0;
    repeat (8000) begin
      @(posedge sys_clk);
      #1;
      if (med_tick_500k === 1'b1) n5++;
      if (med_tick_31k === 1'b1) n31++;
    end
    chk(n5[7:0], 8'h10);
    chk(n31[7:0], 8'h01);
    reg_wr(12'h893, 8'h00);
    n5 = 0;
    repeat (4000) begin
      @(posedge sys_clk);
      #1;
      if (med_tick_500k === 1'b1) n5++;
    end
    chk(n5[7:0], 8'h08);
    foreach (v[b]) begin
      if (8'h74 >> b & 8'h01) begin
        reg_wr(12'h891, 8'h01 << b);
        wait_cyc(600);
        reg_rd(12'h890, exp_rdy(8'h01 << b, 5'h00));
        reg_wr(12'h891, 8'h00);
        wait_cyc(4);
        reg_rd(12'h890, 8'h00);
      end
    end
    for (int i = 0; i < 4; i++) begin
      req <= (i == 0) ? 5'h01 : 5'($random(seed));
      wait_cyc(600);
      reg_rd(12'h890, exp_rdy(8'h00, req));
      req <= 5'h00;
      wait_cyc(4);
      reg_rd(12'h890, 8'h00);
    end
    prev = 8'h00;
    for (int c = 0; c < 8; c++) begin
      v = 8'($random(seed));
      reg_wr(12'h893, {v[7:3], c[2:0]});
      if (c < 6) prev = {5'h00, c[2:0]};
      reg_rd(12'h893, prev);
      chk({5'h00, fast_rate_out}, prev);
    end
    prev = 8'h00;
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h1f : (i == 1) ? 8'h20 : (i == 2) ? 8'h00 : 8'($random(seed));
      if (i > 2) v[5:0] = prev[5:0] ^ 6'h2a;
      reg_wr(12'h892, v);
      wait_cyc(1);
      chk({7'h00, fast_trim_out === v[5:0]}, 8'h00);
      reg_rd(12'h892, v & 8'h3f);
      wait_cyc(300);
      chk({2'h0, fast_trim_out}, v & 8'h3f);
      prev = v;
    end
    // A write while the clock enable is low must not land
    @(posedge sys_clk);
    clk_en <= 1'b0;
    reg_wr(12'h892, prev[7:0] ^ 8'h15);
    clk_en <= 1'b1;
    reg_rd(12'h892, prev & 8'h3f);
    finish_test();
  end
endmodule
`default_nettype wire
